// ### hdl/svp_group_dup.sv
`timescale 1ns/100ps
`default_nettype none
module svp_group_dup
  import svp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire svp_vec_s group,
  input wire logic [2:0] groupLog,
  input wire logic dupEn,
  output svp_vec_s vecOut
);

  // ======================================
  // replication
  // padded lanes of the group are copied too
  function automatic svp_vec_s replicate(
    input svp_vec_s g,
    input logic [2:0] gl,
    input logic dup
  );
    svp_vec_s r;
    logic [5:0] span;
    logic [5:0] src;
    r = '0;
    span = 6'((7'h01 << gl) - 7'h01);
    for (int b = 0; b < SVP_VEC_BYTES; b++) begin
      src = 6'(b) & span;
      if (dup || ((6'(b) & ~span) == 6'h00)) begin
        r.data[b*8 +: 8] = g.data[src*8 +: 8];
        r.laneValid[b] = g.laneValid[src];
      end
    end
    return r;
  endfunction : replicate

  // ======================================
  // output register, loaded once per vector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vecOut <= '0;
    end else if (load) begin
      vecOut <= replicate(group, groupLog, dupEn);
    end
  end

endmodule : svp_group_dup
`default_nettype wire

// ### hdl/svp_packer.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module svp_packer
  import svp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // element stream from fetch side
  input wire logic elemValid,
  output logic elemReady,
  input wire logic [63:0] elemData,
  input wire logic elemEnd,
  // vectors to the cpu
  output logic vecValid,
  input wire logic vecReady,
  output logic [511:0] vecData,
  output logic [63:0] vecLaneValid,
  output logic [63:0] vecPred
);

  // ======================================
  // helpers

  // place one element at its slot;
  // byte b of the vector is lane-ordered
  function automatic svp_vec_s placeElem(
    input logic [63:0] d,
    input logic [1:0] esz,
    input logic cplx,
    input logic swap,
    input logic [6:0] slot
  );
    svp_vec_s r;
    logic [6:0] off;
    logic [6:0] rel;
    logic [2:0] relB;
    logic [3:0] nb;
    logic [2:0] half;
    r = '0;
    nb = 4'(4'h1 << esz);
    half = 3'(nb >> 1);
    off = 7'(slot << esz);
    for (int b = 0; b < SVP_VEC_BYTES; b++) begin
      rel = 7'(b) - off;
      if ((7'(b) >= off) && (rel < 7'(nb))) begin
        relB = rel[2:0];
        if (cplx && swap) begin
          relB = relB ^ half;
        end
        r.data[b*8 +: 8] = d[relB*8 +: 8];
        r.laneValid[b] = 1'b1;
      end
    end
    return r;
  endfunction : placeElem

  // group size in bytes, log2, kept within one vector
  function automatic logic [2:0] groupLogOf(
    input logic [1:0] esz,
    input logic [2:0] vlen
  );
    logic [3:0] s;
    s = 4'(esz) + 4'(vlen);
    if (s > 4'(SVP_MAX_LOG)) begin
      s = 4'(SVP_MAX_LOG);
    end
    return s[2:0];
  endfunction : groupLogOf

  // ======================================
  // registers and state

  svp_cfg_s cfg;
  logic [15:0] innerCnt;
  logic [15:0] transCnt;
  logic [15:0] vecCount;
  svp_state_e state;
  svp_vec_s acc;
  logic [6:0] slotIdx;
  logic [15:0] innerIdx;
  logic pendEnd;

  logic wrEn;
  logic rdSetup;
  logic startPulse;
  logic addrOk;
  logic [31:0] next_prdata;
  logic elemFire;
  logic slotFree;
  logic dupLoad;
  logic groupClose;
  logic innerLast;
  logic [2:0] groupLog;
  logic [2:0] elemsLog;
  logic [6:0] slotLast;
  logic [15:0] innerLimit;
  logic [2:0] subLog;
  logic [6:0] laneCount;
  svp_vec_s placed;
  svp_vec_s dupIn;
  svp_vec_s dupOut;

  // ======================================
  // apb decode

  assign wrEn = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  // zero wait states: read data is caught in
  // the setup cycle so it stands registered
  assign pready = 1'b1;
  assign addrOk = (paddr == SVP_CTRL_OFS) |
                  (paddr == SVP_INNER_OFS) |
                  (paddr == SVP_TCNT_OFS) |
                  (paddr == SVP_STAT_OFS);
  // unmapped offsets answer with an error
  assign pslverr = psel & penable & ~addrOk;
  assign startPulse = wrEn & (paddr == SVP_CTRL_OFS) &
                      pwdata[SVP_START_BIT];

  // control register, start bit is not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= SVP_CFG_RST;
    end else if (wrEn && paddr == SVP_CTRL_OFS) begin
      cfg.cplx <= pwdata[SVP_CPLX_BIT];
      cfg.swap <= pwdata[SVP_SWAP_BIT];
      cfg.dupEn <= pwdata[SVP_DUP_BIT];
      cfg.transpose <= pwdata[SVP_TRANS_BIT];
      cfg.eszLog <= pwdata[SVP_ESZ_LSB +: 2];
      cfg.vlenLog <= pwdata[SVP_VLEN_LSB +: 3];
    end
  end

  // innermost counts, linear and transposed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      innerCnt <= SVP_INNER_RST;
      transCnt <= SVP_TCNT_RST;
    end else if (wrEn) begin
      if (paddr == SVP_INNER_OFS) begin
        innerCnt <= pwdata[15:0];
      end
      if (paddr == SVP_TCNT_OFS) begin
        transCnt <= pwdata[15:0];
      end
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      SVP_CTRL_OFS: begin
        next_prdata[SVP_CPLX_BIT] = cfg.cplx;
        next_prdata[SVP_SWAP_BIT] = cfg.swap;
        next_prdata[SVP_DUP_BIT] = cfg.dupEn;
        next_prdata[SVP_TRANS_BIT] = cfg.transpose;
        next_prdata[SVP_ESZ_LSB +: 2] = cfg.eszLog;
        next_prdata[SVP_VLEN_LSB +: 3] = cfg.vlenLog;
      end
      SVP_INNER_OFS: begin
        next_prdata[15:0] = innerCnt;
      end
      SVP_TCNT_OFS: begin
        next_prdata[15:0] = transCnt;
      end
      SVP_STAT_OFS: begin
        next_prdata[SVP_STATE_LSB +: 2] = state;
        next_prdata[SVP_LANES_LSB +: 7] = laneCount;
        next_prdata[SVP_VCNT_LSB +: 16] = vecCount;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= next_prdata;
    end
  end

  // ======================================
  // geometry

  // sub-element width sets the lane width
  assign subLog = 3'(cfg.eszLog) - 3'(cfg.cplx);
  assign laneCount = 7'(7'h40 >> subLog);
  assign groupLog = groupLogOf(cfg.eszLog, cfg.vlenLog);
  assign elemsLog = groupLog - 3'(cfg.eszLog);
  assign slotLast = 7'((8'h01 << elemsLog) - 8'h01);
  // a zero count would never close; treat as one
  assign innerLimit = cfg.transpose ? transCnt : innerCnt;
  assign innerLast = (innerLimit == 16'h0000) |
                     (innerIdx == innerLimit - 16'h0001);

  // ======================================
  // handshakes

  assign elemReady = (state == ST_FILL);
  assign elemFire = elemValid & elemReady;
  assign slotFree = ~vecValid | vecReady;
  assign groupClose = (slotIdx == slotLast) | innerLast | elemEnd;
  assign placed = placeElem(elemData, cfg.eszLog,
                            cfg.cplx, cfg.swap, slotIdx);
  assign dupLoad = slotFree &
                   ((state == ST_PUSH) | (state == ST_DONE));
  // past stream end the group is all zero
  assign dupIn = (state == ST_DONE) ? '0 : acc;

  // ======================================
  // sequencing

  // fill a group, hand it over, repeat
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else if (startPulse) begin
      state <= ST_FILL;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_FILL: begin
          if (elemFire && groupClose) begin
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (slotFree) begin
            state <= pendEnd ? ST_DONE : ST_FILL;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // end-of-stream seen with the closing element
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pendEnd <= 1'b0;
    end else if (startPulse) begin
      pendEnd <= 1'b0;
    end else if (elemFire && groupClose) begin
      pendEnd <= elemEnd;
    end
  end

  // slot within the group
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slotIdx <= 7'h00;
    end else if (startPulse) begin
      slotIdx <= 7'h00;
    end else if (elemFire) begin
      slotIdx <= groupClose ? 7'h00 : slotIdx + 7'h01;
    end
  end

  // position within the innermost dimension
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      innerIdx <= 16'h0000;
    end else if (startPulse) begin
      innerIdx <= 16'h0000;
    end else if (elemFire) begin
      innerIdx <= innerLast ? 16'h0000 : innerIdx + 16'h0001;
    end
  end

  // ======================================
  // assembly

  // cleared lanes stay zero and invalid,
  // so padding needs no extra logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
    end else if (startPulse || dupLoad) begin
      acc <= '0;
    end else if (elemFire) begin
      acc.data <= acc.data | placed.data;
      acc.laneValid <= acc.laneValid | placed.laneValid;
    end
  end

  // ======================================
  // output slot

  svp_group_dup u_dup (
    .clk(clk),
    .rst_b(rst_b),
    .load(dupLoad),
    .group(dupIn),
    .groupLog(groupLog),
    .dupEn(cfg.dupEn),
    .vecOut(dupOut)
  );

  // one vector held until the cpu takes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vecValid <= 1'b0;
    end else if (dupLoad) begin
      vecValid <= 1'b1;
    end else if (vecReady) begin
      vecValid <= 1'b0;
    end
  end

  // vectors taken, wraps silently
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vecCount <= 16'h0000;
    end else if (startPulse) begin
      vecCount <= 16'h0000;
    end else if (vecValid && vecReady) begin
      vecCount <= vecCount + 16'h0001;
    end
  end

  // lane 0 sits in the low bits
  assign vecData = dupOut.data;
  assign vecLaneValid = dupOut.laneValid;
  // predicates are not supported by the cpu
  assign vecPred = 64'h0000_0000_0000_0000;

endmodule : svp_packer
`default_nettype wire

// ### inc/svp_pkg.sv
`default_nettype none
package svp_pkg;
  // ======================================
  // geometry
  localparam int SVP_VEC_BYTES = 64;
  localparam int SVP_ELEM_BYTES = 8;
  localparam logic [2:0] SVP_MAX_LOG = 3'h6;
  // ======================================
  // register offsets
  localparam logic [11:0] SVP_CTRL_OFS = 12'h000;
  localparam logic [11:0] SVP_INNER_OFS = 12'h004;
  localparam logic [11:0] SVP_TCNT_OFS = 12'h008;
  localparam logic [11:0] SVP_STAT_OFS = 12'h00c;
  // ======================================
  // control fields
  localparam int SVP_START_BIT = 0;
  localparam int SVP_CPLX_BIT = 1;
  localparam int SVP_SWAP_BIT = 2;
  localparam int SVP_DUP_BIT = 3;
  localparam int SVP_TRANS_BIT = 4;
  localparam int SVP_ESZ_LSB = 8;
  localparam int SVP_VLEN_LSB = 12;
  // status fields
  localparam int SVP_STATE_LSB = 0;
  localparam int SVP_LANES_LSB = 8;
  localparam int SVP_VCNT_LSB = 16;
  // ======================================
  // reset values
  localparam logic [15:0] SVP_INNER_RST = 16'h0001;
  localparam logic [15:0] SVP_TCNT_RST = 16'h0001;
  // ======================================
  // types
  typedef struct packed {
    logic cplx;
    logic swap;
    logic dupEn;
    logic transpose;
    logic [1:0] eszLog;
    logic [2:0] vlenLog;
  } svp_cfg_s;
  localparam svp_cfg_s SVP_CFG_RST = '0;
  typedef struct packed {
    logic [511:0] data;
    logic [63:0] laneValid;
  } svp_vec_s;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FILL,
    ST_PUSH,
    ST_DONE
  } svp_state_e;
endpackage : svp_pkg
`default_nettype wire

// ### testbench/svp_consumer.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// cpu side vector consumer
module svp_consumer
  import svp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic take,
  input wire logic slow,
  input wire logic vecValid,
  input wire logic [511:0] vecData,
  input wire logic [63:0] vecLaneValid,
  output logic vecReady
);
  svp_vec_s got[$];
  logic [1:0] beat;
  // slow mode takes one beat in four, so vectors wait in the slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) beat <= 2'h0;
    else beat <= beat + 2'h1;
  end
  assign vecReady = take && (!slow || beat == 2'h0);
  // each vector is kept whole as it is taken
  always @(posedge clk) begin
    if (rst_b && vecValid && vecReady) got.push_back({vecData, vecLaneValid});
  end
endmodule : svp_consumer
`default_nettype wire

// ### testbench/svp_packer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// port checker for the packer
module svp_packer_monitor
  import svp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic elemValid,
  input wire logic elemReady,
  input wire logic elemEnd,
  input wire logic vecValid,
  input wire logic vecReady,
  input wire logic [511:0] vecData,
  input wire logic [63:0] vecLaneValid,
  input wire logic [63:0] vecPred
);
  logic [511:0] padBits;
  // byte mask widened to bits so a pad lane is checked whole
  always_comb begin
    for (int b = 0; b < 64; b++) begin
      padBits[b*8 +: 8] = {8{~vecLaneValid[b]}};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence lastTaken;
    elemValid && elemReady && elemEnd;
  endsequence
  sequence heldVec;
    vecValid && !vecReady;
  endsequence
  pred_zero_a: assert property (vecPred == 64'h0)
    else $error("predicate not zero");
  pad_zero_a: assert property ((vecData & padBits) == 512'h0)
    else $error("pad lane not zero");
  lane_first_a: assert property (vecValid && vecLaneValid != 64'h0 |-> vecLaneValid[0])
    else $error("lane zero empty");
  vec_hold_a: assert property (heldVec |=> vecValid && $stable(vecData) && $stable(vecLaneValid))
    else $error("vector changed while held");
  end_push_a: assert property (lastTaken |-> ##[1:40] vecValid)
    else $error("no vector after stream end");
  group_close_a: assert property (lastTaken |=> !elemReady)
    else $error("ready after closing element");
  no_wait_a: assert property (psel |-> pready)
    else $error("wait state seen");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  unmapped_a: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not flagged");
endmodule : svp_packer_monitor
bind svp_packer svp_packer_monitor svp_packer_monitor_i (.clk, .rst_b, .paddr, .psel, .penable, .pready,
  .pslverr, .elemValid, .elemReady, .elemEnd, .vecValid, .vecReady, .vecData, .vecLaneValid, .vecPred);
`default_nettype wire

// ### testbench/tb_svp_packer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_svp_packer;
  import svp_pkg::*;
  typedef struct {int cplx, swap, dup, trans, esz, vlen, inn, tcn, tot, slow;} svp_row_s;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, elemValid, elemReady, elemEnd;
  logic vecValid, vecReady, take, slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [63:0] elemData, vecLaneValid, vecPred;
  logic [511:0] vecData;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  svp_row_s rows[7] = '{'{0,0,0,0,3,3,29,1,29,0}, '{0,0,0,0,3,2,29,1,29,1}, '{0,0,1,0,3,1,29,1,29,0},
    '{1,0,0,0,2,6,5,1,10,0}, '{1,1,1,0,1,2,4,1,4,1}, '{0,0,0,1,0,6,3,7,14,0}, '{0,0,1,0,2,0,3,1,3,1}};
  svp_packer svp_packer_i (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .elemValid, .elemReady, .elemData, .elemEnd, .vecValid, .vecReady, .vecData, .vecLaneValid,
    .vecPred);
  svp_consumer svp_consumer_i (.clk, .rst_b, .take, .slow, .vecValid, .vecData, .vecLaneValid, .vecReady);
  // ======================================
  // helpers
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [575:0] exp, input logic [575:0] seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer; an idle edge follows so psel is never set twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the very edge where pready is seen high
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic send(input logic [63:0] d, input logic last);
    elemValid <= 1'b1; elemData <= d; elemEnd <= last;
    // held until the edge that samples ready high
    do @(posedge clk); while (elemReady !== 1'b1);
  endtask : send
  function automatic logic [63:0] elem(input int k);
    for (int i = 0; i < 8; i++) elem[i*8 +: 8] = 8'(k*8 + i + 1);
  endfunction : elem
  // expected vector: element j at byte j*eb upward, then group copies
  function automatic svp_vec_s expv(input svp_row_s r, input int base, input int c, input int glog);
    int eb;
    logic [63:0] v;
    eb = 1 << r.esz;
    expv = '0;
    for (int j = 0; j < c; j++) begin
      v = elem(base + j);
      for (int i = 0; i < eb; i++) begin
        expv.data[(j*eb+i)*8 +: 8] = v[((r.cplx && r.swap) ? (i + eb/2) % eb : i)*8 +: 8];
        expv.laneValid[j*eb+i] = 1'b1;
      end
    end
    for (int b = 1 << glog; b < 64 && r.dup != 0; b++) begin
      expv.data[b*8 +: 8] = expv.data[(b % (1 << glog))*8 +: 8];
      expv.laneValid[b] = expv.laneValid[b % (1 << glog)];
    end
  endfunction : expv
  task automatic run(input svp_row_s r);
    int n, glog, epg, nexp;
    logic [31:0] ctl;
    n = r.trans != 0 ? r.tcn : r.inn;
    glog = (r.vlen + r.esz > 6) ? 6 : r.vlen + r.esz;
    epg = 1 << (glog - r.esz);
    nexp = (r.tot / n) * ((n + epg - 1) / epg);
    ctl = 32'(1 | r.cplx << 1 | r.swap << 2 | r.dup << 3 | r.trans << 4 | r.esz << 8 | r.vlen << 12);
    take <= 1'b0; slow <= r.slow[0];
    apb(1'b1, SVP_INNER_OFS, 32'(r.inn));
    apb(1'b1, SVP_TCNT_OFS, 32'(r.tcn));
    svp_consumer_i.got.delete();
    apb(1'b1, SVP_CTRL_OFS, ctl);
    apb(1'b0, SVP_CTRL_OFS, 32'h0);
    check("ctrl", 576'(ctl & ~32'h1), 576'(q));
    apb(1'b0, SVP_STAT_OFS, 32'h0);
    check("lanes", 576'(64 >> (r.esz - r.cplx)), 576'(q[14:8]));
    take <= 1'b1;
    for (int k = 0; k < r.tot; k++) send(elem(k), k == r.tot - 1);
    elemValid <= 1'b0;
    for (int k = 0; k < 3000 && svp_consumer_i.got.size() < nexp + 2; k++) @(posedge clk);
    // a vector left in the slot by the previous run is empty
    while (svp_consumer_i.got.size() > 0 && svp_consumer_i.got[0].laneValid === 64'h0) svp_consumer_i.got.delete(0);
    // an empty queue would pop zeros and hide a missing vector
    check("count", 576'h1, 576'(svp_consumer_i.got.size() > nexp));
    for (int w = 0; w < r.tot / n; w++) begin
      for (int s = 0; s < n; s += epg) begin
        check("vector", expv(r, w*n + s, (n - s < epg) ? n - s : epg, glog), svp_consumer_i.got.pop_front());
      end
    end
    check("past end", 576'h0, svp_consumer_i.got.pop_front());
  endtask : run
  // ======================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ======================================
  // main sequence
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    elemValid = 1'b0; elemData = '0; elemEnd = 1'b0; take = 1'b0; slow = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("idle", 576'h0, 576'({vecValid, elemReady}));
    apb(1'b0, SVP_INNER_OFS, 32'h0);
    check("inner", 576'(SVP_INNER_RST), 576'(q));
    apb(1'b0, SVP_TCNT_OFS, 32'h0);
    check("tcnt", 576'(SVP_TCNT_RST), 576'(q));
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 576'h1, 576'({q, e}));
    foreach (rows[i]) run(rows[i]);
    // reset in mid stream drops everything
    take <= 1'b0;
    apb(1'b1, SVP_CTRL_OFS, 32'h3301);
    send(elem(0), 1'b0);
    elemValid <= 1'b0;
    rst_b <= 1'b0;
    @(negedge clk);
    check("mid reset", 576'h0, 576'({vecValid, elemReady, vecLaneValid}));
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("rst idle", 576'h0, 576'({vecValid, elemReady, prdata}));
    apb(1'b0, SVP_STAT_OFS, 32'h0);
    check("rst stat", 576'(64 << SVP_LANES_LSB), 576'(q));
    print_verdict();
  end
endmodule : tb_svp_packer
`default_nettype wire
